// file: relay_timing_functions.sv
// relay timing functions: one-shot, repeat cycle, pulse generator
// assumes supply, trigger and function inputs come from pins
//
// Summary of operation
// - one-shot accepts triggers once supply present
// - trigger energizes contact and starts delay
// - delay expiry de-energizes contact
// - retrigger restarts delay, contact stays on
// - fast trigger cycling holds contact on
// - supply loss returns contact to shelf
// - repeat: energize at supply, start delay
// - repeat: off interval equals preset delay
// - repeat: alternate while supply stays present
// - repeat and pulse ignore trigger input
// - pulse: wait delay, then fixed pulse
// - one pulse per power-up
`timescale 1ns/1ps
module relay_timing_functions #(
   parameter int unsigned TICK_CYCLES = relay_timing_pkg::TICK_CYCLES,
   parameter int unsigned PULSE_TICKS = relay_timing_pkg::PULSE_TICKS
) (
   input  wire logic                                clk_sys,
   input  wire logic                                nrst,
   input  wire logic                                supplyIn,
   input  wire logic                                triggerIn,
   input  wire logic [1:0]                          funcSel,
   input  wire logic [relay_timing_pkg::DELAY_W-1:0] presetTicks,
   output logic                                     contactOut
);
   localparam int unsigned W = relay_timing_pkg::DELAY_W;
   localparam logic [W-1:0] PULSE_LAST = W'(PULSE_TICKS - 1);

   typedef struct packed {
      logic [1:0]                supSync;
      logic [1:0]                trgSync;
      logic [1:0][1:0]           fnSync;
      logic [1:0][W-1:0]         dlySync;
      logic                      trgPrev;
      relay_timing_pkg::func_t   func;
      relay_timing_pkg::state_t  state;
      logic [W-1:0]              cnt;
      logic                      contact;
   } rt_t;

   rt_t st_reg;
   rt_t st_next;
   tick_if tk ();

   // ---------------------------------------------------------------
   // timebase
   // ---------------------------------------------------------------
   relay_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .tk      (tk.src)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // true when an interval of len ticks has fully elapsed
   function automatic logic expired(input logic [W-1:0] c,
                                    input logic [W-1:0] len);
      expired = (len == '0) || (c >= len - 1'b1);
   endfunction

   function automatic relay_timing_pkg::func_t decode_func(
      input logic [1:0] f);
      case (f)
         2'h1:    decode_func = relay_timing_pkg::FN_REPEAT;
         2'h2:    decode_func = relay_timing_pkg::FN_PULSE;
         default: decode_func = relay_timing_pkg::FN_ONESHOT;
      endcase
   endfunction

   logic         supply;
   logic         trig;
   logic         trigRise;
   logic         tick;
   logic [W-1:0] preset;
   logic [W-1:0] onLen;

   assign supply   = st_reg.supSync[1];
   assign trig     = st_reg.trgSync[1];
   assign trigRise = trig && !st_reg.trgPrev;
   assign tick     = tk.tick;
   assign preset   = st_reg.dlySync[1];
   // pulse length is fixed; other modes time the preset
   assign onLen    = (st_reg.func == relay_timing_pkg::FN_PULSE) ?
                     PULSE_LAST + 1'b1 : preset;

   // ---------------------------------------------------------------
   // function state machine
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.supSync = {st_reg.supSync[0], supplyIn};
      st_next.trgSync = {st_reg.trgSync[0], triggerIn};
      st_next.trgPrev = trig;
      st_next.fnSync  = {st_reg.fnSync[0], funcSel};
      st_next.dlySync = {st_reg.dlySync[0], presetTicks};
      if (tick) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
      if (!supply) begin
         // static select latched only while unpowered
         st_next.func    = decode_func(st_reg.fnSync[1]);
         st_next.state   = relay_timing_pkg::ST_IDLE;
         st_next.contact = 1'b0;
         st_next.cnt     = '0;
      end else begin
         case (st_reg.state)
            relay_timing_pkg::ST_IDLE: begin
               st_next.cnt = '0;
               case (st_reg.func)
                  relay_timing_pkg::FN_REPEAT: begin
                     st_next.state   = relay_timing_pkg::ST_ON;
                     st_next.contact = 1'b1;
                  end
                  relay_timing_pkg::FN_PULSE: begin
                     st_next.state = relay_timing_pkg::ST_WAIT;
                  end
                  default: begin
                     if (trigRise) begin
                        st_next.state   = relay_timing_pkg::ST_ON;
                        st_next.contact = 1'b1;
                     end
                  end
               endcase
            end
            relay_timing_pkg::ST_ON: begin
               if (st_reg.func == relay_timing_pkg::FN_ONESHOT &&
                   trigRise) begin
                  st_next.cnt = '0;
               end else if (tick && expired(st_reg.cnt, onLen)) begin
                  st_next.cnt = '0;
                  st_next.contact = 1'b0;
                  if (st_reg.func == relay_timing_pkg::FN_REPEAT) begin
                     st_next.state = relay_timing_pkg::ST_OFF;
                  end else if (st_reg.func ==
                               relay_timing_pkg::FN_PULSE) begin
                     st_next.state = relay_timing_pkg::ST_DONE;
                  end else begin
                     st_next.state = relay_timing_pkg::ST_IDLE;
                  end
               end
            end
            relay_timing_pkg::ST_OFF: begin
               // trigger never looked at here
               if (tick && expired(st_reg.cnt, preset)) begin
                  st_next.cnt     = '0;
                  st_next.state   = relay_timing_pkg::ST_ON;
                  st_next.contact = 1'b1;
               end
            end
            relay_timing_pkg::ST_WAIT: begin
               if (tick && expired(st_reg.cnt, preset)) begin
                  st_next.cnt     = '0;
                  st_next.state   = relay_timing_pkg::ST_ON;
                  st_next.contact = 1'b1;
               end
            end
            relay_timing_pkg::ST_DONE: begin
               // hold until supply drops; only a power cycle rearms
               st_next.cnt = '0;
            end
            default: begin
               st_next.state   = relay_timing_pkg::ST_IDLE;
               st_next.contact = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '{supSync: 2'h0, trgSync: 2'h0, trgPrev: 1'b0,
                    fnSync: '0, dlySync: '0,
                    func: relay_timing_pkg::FN_ONESHOT,
                    state: relay_timing_pkg::ST_IDLE,
                    cnt: '0, contact: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign contactOut = st_reg.contact;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_shelf;
      @(posedge clk_sys) disable iff (!nrst)
      !supply |=> !contactOut;
   endproperty
   a_shelf: assert property (p_shelf)
      else $error("contact on without supply");

   property p_trig_on;
      @(posedge clk_sys) disable iff (!nrst)
      supply && st_reg.func == relay_timing_pkg::FN_ONESHOT && trigRise
      |=> contactOut;
   endproperty
   a_trig_on: assert property (p_trig_on)
      else $error("trigger did not energize contact");

   property p_retrig;
      @(posedge clk_sys) disable iff (!nrst)
      supply && st_reg.func == relay_timing_pkg::FN_ONESHOT && trigRise
      && st_reg.state == relay_timing_pkg::ST_ON |=> st_reg.cnt == '0;
   endproperty
   a_retrig: assert property (p_retrig)
      else $error("retrigger did not restart delay");

   property p_repeat_start;
      @(posedge clk_sys) disable iff (!nrst)
      $rose(supply) && st_reg.func == relay_timing_pkg::FN_REPEAT
      |=> contactOut;
   endproperty
   a_repeat_start: assert property (p_repeat_start)
      else $error("repeat did not start energized");

   property p_oneshot_off;
      @(posedge clk_sys) disable iff (!nrst)
      $fell(contactOut) && supply &&
      st_reg.func == relay_timing_pkg::FN_ONESHOT
      |-> st_reg.state == relay_timing_pkg::ST_IDLE;
   endproperty
   a_oneshot_off: assert property (p_oneshot_off)
      else $error("one-shot release into wrong state");

   property p_repeat_off;
      @(posedge clk_sys) disable iff (!nrst)
      $fell(contactOut) && supply && $past(supply) &&
      st_reg.func == relay_timing_pkg::FN_REPEAT
      |-> st_reg.state == relay_timing_pkg::ST_OFF && st_reg.cnt == '0;
   endproperty
   a_repeat_off: assert property (p_repeat_off)
      else $error("repeat off interval not started");

   property p_one_pulse;
      @(posedge clk_sys) disable iff (!nrst)
      st_reg.state == relay_timing_pkg::ST_DONE && supply
      |=> !contactOut;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("second pulse in one power-up");

   property p_func_static;
      @(posedge clk_sys) disable iff (!nrst)
      supply && $past(supply) |-> $stable(st_reg.func);
   endproperty
   a_func_static: assert property (p_func_static)
      else $error("function changed while powered");
endmodule

// file: relay_timing_pkg.sv
// constants and types for the relay timing functions block
// assumes a single 125 MHz system clock
package relay_timing_pkg;
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned TICK_US      = 1000;
   localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned PULSE_MS     = 500;
   localparam int unsigned PULSE_TICKS  = PULSE_MS * 1000 / TICK_US;
   localparam int unsigned DELAY_W      = 24;
   localparam int unsigned DIV_W        = 20;

   typedef enum logic [1:0] {
      FN_ONESHOT = 2'h0,
      FN_REPEAT  = 2'h1,
      FN_PULSE   = 2'h2
   } func_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_ON    = 5'h02,
      ST_OFF   = 5'h04,
      ST_WAIT  = 5'h08,
      ST_DONE  = 5'h10
   } state_t;
endpackage

// file: tick_if.sv
// timebase tick carrier between the top and its tick generator
// assumes one clock domain
`timescale 1ns/1ps
interface tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface

// file: relay_tick_gen.sv
// free-running timebase tick generator
// assumes clk_sys at the package rate
`timescale 1ns/1ps
module relay_tick_gen #(
   parameter int unsigned TICK_CYCLES = relay_timing_pkg::TICK_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   tick_if.src       tk
);
   typedef struct packed {
      logic [relay_timing_pkg::DIV_W-1:0] div;
      logic                               tick;
   } tg_t;

   localparam int unsigned   DW       = relay_timing_pkg::DIV_W;
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

   tg_t st_reg;
   tg_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = (st_reg.div == DIV_LAST);
      if (st_reg.div == DIV_LAST) begin
         st_next.div = '0;
      end else begin
         st_next.div = st_reg.div + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tk.tick = st_reg.tick;
endmodule

// file: switch_partner.sv
// trigger switch model: single presses or steady cycling
// assumes the bench drives press and cycleEn just after clk_sys edges
`timescale 1ns/1ps
module switch_partner #(
   parameter int unsigned HALF = 12
) (
   input  wire logic clk_sys,
   input  wire logic press,
   input  wire logic cycleEn,
   output logic      triggerIn
);
   // ------------------------------
   // cycling phase
   // ------------------------------
   int unsigned phase;
   always_ff @(posedge clk_sys) begin
      if (!cycleEn) phase <= 0;
      else if (phase == 2 * HALF - 1) phase <= 0;
      else phase <= phase + 1;
   end
   // closed in first half; full period kept below the preset delay
   assign triggerIn = press | (cycleEn & (phase < HALF));
endmodule

// file: testbench.sv
// testbench: table of timing cases, then hand-written edge cases
// assumes short tick and pulse counts; delay of 5 ticks unless changed
`timescale 1ns/1ps
module testbench;
   // ------------------------------
   // signals and instances
   // ------------------------------
   localparam int unsigned TCK = 8;
   localparam int unsigned PLS = 3;
   typedef struct {
      logic [1:0] fn;
      int         dly;
      logic       exp;
   } row_t;
   logic                                 clk_sys     = 1'b0;
   logic                                 nrst        = 1'b1;
   logic                                 supplyIn    = 1'b0;
   logic                                 press       = 1'b0;
   logic                                 cycleEn     = 1'b0;
   logic                                 triggerIn;
   logic [1:0]                           funcSel     = 2'h0;
   logic [relay_timing_pkg::DELAY_W-1:0] presetTicks = 24'h000005;
   logic                                 contactOut;
   int                                   nMismatch   = 0;
   int                                   checks      = 0;
   int                                   cycles      = 0;
   // check points kept clear of the one-tick timebase uncertainty
   row_t rows [11] = '{'{2'h0, 15, 1'b1}, '{2'h0, 55, 1'b0},
      '{2'h3, 15, 1'b1}, '{2'h1, 20, 1'b1}, '{2'h1, 60, 1'b0},
      '{2'h1, 100, 1'b1}, '{2'h1, 140, 1'b0}, '{2'h2, 20, 1'b0},
      '{2'h2, 52, 1'b1}, '{2'h2, 80, 1'b0}, '{2'h2, 400, 1'b0}};
   relay_timing_functions #(.TICK_CYCLES(TCK), .PULSE_TICKS(PLS))
      relay_timing_functions_inst (.clk_sys(clk_sys), .nrst(nrst),
      .supplyIn(supplyIn), .triggerIn(triggerIn), .funcSel(funcSel),
      .presetTicks(presetTicks), .contactOut(contactOut));
   switch_partner switch_partner_inst (.clk_sys(clk_sys), .press(press),
      .cycleEn(cycleEn), .triggerIn(triggerIn));
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task automatic check(input string what, input logic seen,
                        input logic exp);
      checks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[FAIL] %s expected %b seen %b", what, exp, seen);
      end
   endtask
   // function is only taken while supply is absent
   task automatic power(input logic [1:0] fn);
      supplyIn = 1'b0;
      funcSel = fn;
      step(6);
      supplyIn = 1'b1;
   endtask
   task automatic print_verdict;
      $display("mismatches %0d, checks %0d", nMismatch, checks);
      if (nMismatch == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ------------------------------
   // clock, timeout, sequence
   // ------------------------------
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         nMismatch++;
         print_verdict();
      end
   end
   initial begin
      #1 nrst = 1'b0;
      step(2);
      check("contact in reset", contactOut, 1'b0);
      nrst = 1'b1;
      step(2);
      check("contact after reset", contactOut, 1'b0);
      foreach (rows[i]) begin
         power(rows[i].fn);
         if (rows[i].fn == 2'h0 || rows[i].fn == 2'h3) step(10);
         press = 1'b1;
         step(4);
         press = 1'b0;
         step(rows[i].dly - 4);
         check("table row", contactOut, rows[i].exp);
      end
      power(2'h0);
      step(10);
      cycleEn = 1'b1;
      step(8);
      repeat (150) begin
         check("held by cycling", contactOut, 1'b1);
         step(1);
      end
      cycleEn = 1'b0;
      step(60);
      check("expiry after cycling", contactOut, 1'b0);
      power(2'h0);
      step(1);
      press = 1'b1;
      step(4);
      press = 1'b0;
      step(6);
      check("trigger at supply", contactOut, 1'b1);
      supplyIn = 1'b0;
      step(5);
      check("supply loss one-shot", contactOut, 1'b0);
      supplyIn = 1'b1;
      step(50);
      check("timing abandoned", contactOut, 1'b0);
      power(2'h1);
      step(15);
      supplyIn = 1'b0;
      step(5);
      check("supply loss repeat", contactOut, 1'b0);
      power(2'h1);
      step(10);
      funcSel = 2'h2;
      step(90);
      check("function held", contactOut, 1'b1);
      power(2'h2);
      step(100);
      // the outside party cycles supply to ask for another pulse
      power(2'h2);
      step(52);
      check("second pulse", contactOut, 1'b1);
      step(48);
      press = 1'b1;
      step(4);
      press = 1'b0;
      step(6);
      check("trigger ignored", contactOut, 1'b0);
      step(242);
      check("single pulse", contactOut, 1'b0);
      presetTicks = 24'h000000;
      power(2'h0);
      step(10);
      press = 1'b1;
      step(4);
      press = 1'b0;
      step(16);
      check("zero delay", contactOut, 1'b0);
      print_verdict();
   end
endmodule
